// ==== logic/qvd_pkg.sv ====
`default_nettype none
package qvd_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int QVD_CHANNELS   = 4;
  localparam int QVD_SAMPLE_W   = 9;   // converter resolution
  localparam int QVD_VIDEO_W    = 8;   // output bus width per channel
  localparam int QVD_GAIN_W     = 8;
  localparam int QVD_FIFO_DEPTH = 16;
  localparam int QVD_PIN_COUNT  = 6;   // pins passed through the synchroniser

  // synchroniser bit positions
  localparam int QVD_PIN_STANDBY = 0;
  localparam int QVD_PIN_RESET   = 1;
  localparam int QVD_PIN_STRAP0  = 2;
  localparam int QVD_PIN_STRAP1  = 3;
  localparam int QVD_PIN_TEST    = 4;
  localparam int QVD_PIN_REFCLK  = 5;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  QVD_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  QVD_GAIN_BASE  = 8'h10;
  localparam logic [7:0]  QVD_STATUS_OFS = 8'h20;
  localparam int          QVD_CTRL_CLK54 = 0;
  localparam int          QVD_CTRL_EMBED = 1;
  localparam int          QVD_CTRL_LINE_PHASE_INDICATOR  = 2;
  localparam int          QVD_CTRL_SEL   = 4;   // 4 bits, composite input b per channel
  localparam int          QVD_CTRL_SVID  = 8;   // 4 bits, s-video pair per channel
  localparam logic [31:0] QVD_CTRL_MASK  = 32'h0000_0ff7;
  localparam logic [31:0] QVD_CTRL_RESET = 32'h0000_0000;
  localparam logic [7:0]  QVD_GAIN_RESET = 8'h80;
  localparam int          QVD_STAT_STBY  = 8;
  localparam int          QVD_STAT_PHASE = 12;
  // upper address bits of the serial slave; value is arbitrary
  localparam logic [4:0]  QVD_SLAVE_BASE = 5'h0b;

  // ----------------------------------------------------------------
  // stream codes and reference
  // ----------------------------------------------------------------
  localparam logic [7:0]  QVD_SYNC_CODE    = 8'hff;  // first byte of an embedded code
  localparam int          QVD_REF_FREQ_KHZ = 14318;  // reference crystal, 14.31818 MHz

  typedef enum logic [1:0] {QVD_ACTIVE, QVD_STANDBY, QVD_RESTART} qvd_mode_type;

  typedef struct packed {
    logic [1:0]              chan;
    logic [QVD_SAMPLE_W-1:0] value;
    logic                    lineStart;
    logic                    fieldStart;
  } qvd_sample_type;

  typedef logic [QVD_CHANNELS-1:0][QVD_VIDEO_W-1:0] qvd_video_type;
  typedef logic [QVD_CHANNELS-1:0][QVD_GAIN_W-1:0]  qvd_gain_type;

  // byte address of a channel's gain register
  function automatic logic [7:0] qvdGainOfs(input int ch);
    qvdGainOfs = QVD_GAIN_BASE + 8'(ch * 4);
  endfunction : qvdGainOfs

endpackage : qvd_pkg
`default_nettype wire

// ==== logic/qvd_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module qvd_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wrPtrReg;
  logic [AW:0]      wrPtrNext;
  logic [AW:0]      rdPtrReg;
  logic [AW:0]      rdPtrNext;
  logic             pushing;
  logic             popping;

  // ----------------------------------------------------------------
  // flags and pointer steps
  // ----------------------------------------------------------------
  // full when the pointers differ only in the wrap bit
  always_comb begin
    inReady   = (wrPtrReg[AW-1:0] != rdPtrReg[AW-1:0]) || (wrPtrReg[AW] == rdPtrReg[AW]);
    outValid  = wrPtrReg != rdPtrReg;
    pushing   = inValid && inReady;
    popping   = outValid && outReady;
    wrPtrNext = pushing ? wrPtrReg + 1'b1 : wrPtrReg;
    rdPtrNext = popping ? rdPtrReg + 1'b1 : rdPtrReg;
    outData   = store[rdPtrReg[AW-1:0]];
  end

  // storage is not reset; only the pointers need a defined value
  always_ff @(posedge clk) begin
    if (pushing) begin
      store[wrPtrReg[AW-1:0]] <= inData;
    end
    if (rst) begin
      wrPtrReg <= '0;
      rdPtrReg <= '0;
    end else begin
      wrPtrReg <= wrPtrNext;
      rdPtrReg <= rdPtrNext;
    end
  end

endmodule : qvd_fifo
`default_nettype wire

// ==== logic/qvd_ctrl_port.sv ====
// Behaviour
// - pal mode: indicator high noninverted, low inverted
// - standby pin low puts block in standby
// - standby keeps all configuration registers
// - chip reset restores defaults, restarts processor
// - strap pins sampled together at power-on
// - unscaled clock runs at 27 or 54
// - scaled clock at 27 qualifies words
// - 8-bit video, embedded or discrete syncs
// - two composite inputs or one s-video pair
// - composite input switch saves and restores gain
// - 9-bit samples at most reference rate
// - pixel clocks divided from clk, word timing from the reference pin
`timescale 1ns/1ps
`default_nettype none
module qvd_ctrl_port
  import qvd_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            standbyRequestN,
  input  wire logic            chipResetLow,
  input  wire logic            addrStrapBit0,
  input  wire logic            addrStrapBit1,
  input  wire logic            testModeSelect,
  input  wire logic            refClockIn,
  input  wire qvd_sample_type  sampleIn,
  input  wire logic            sampleValid,
  output logic                 sampleReady,
  output logic                 sampleStrobe,
  input  wire logic [7:0]      regAddr,
  input  wire logic [31:0]     regWrData,
  input  wire logic            regWr,
  input  wire logic            regRd,
  output logic [31:0]          regRdData,
  output logic [3:0]           unscaledPixelClock,
  output logic [3:0]           scaledPixelClock,
  output logic [3:0]           lineSyncOut,
  output logic [3:0]           fieldSyncOut,
  output qvd_video_type        channelVideoBus,
  output logic [3:0]           inputSelect,
  output logic [3:0]           sVideoMode,
  output qvd_gain_type         agcGain,
  output logic                 standbyActive,
  output logic                 cpuRestart,
  output logic [6:0]           slaveAddress
);

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  logic [QVD_PIN_COUNT-1:0] pinMetaReg;
  logic [QVD_PIN_COUNT-1:0] pinSyncReg;
  logic                     refPrevReg;
  logic                     refRise;
  logic                     pdnHigh;
  logic                     regReset;

  // the test select pin is synchronised but has no effect while grounded
  always_ff @(posedge clk) begin
    pinMetaReg <= {refClockIn, testModeSelect, addrStrapBit1, addrStrapBit0,
                   chipResetLow, standbyRequestN};
    pinSyncReg <= pinMetaReg;
    refPrevReg <= pinSyncReg[QVD_PIN_REFCLK];
  end

  // reset pin only counts while the standby pin is high
  always_comb begin
    pdnHigh  = pinSyncReg[QVD_PIN_STANDBY];
    refRise  = pinSyncReg[QVD_PIN_REFCLK] && !refPrevReg;
    regReset = rst || (pdnHigh && !pinSyncReg[QVD_PIN_RESET]);
  end

  // ----------------------------------------------------------------
  // mode control and strap latch
  // ----------------------------------------------------------------
  qvd_mode_type modeReg;
  qvd_mode_type modeNext;
  logic [1:0]   strapReg;
  logic [1:0]   strapNext;

  always_comb begin
    modeNext  = modeReg;
    strapNext = strapReg;
    if (rst) begin
      strapNext = {pinSyncReg[QVD_PIN_STRAP1], pinSyncReg[QVD_PIN_STRAP0]};
    end
    case (modeReg)
      QVD_ACTIVE: begin
        if (!pdnHigh) begin
          modeNext = QVD_STANDBY;
        end else if (!pinSyncReg[QVD_PIN_RESET]) begin
          modeNext = QVD_RESTART;
        end
      end
      QVD_STANDBY: begin
        if (pdnHigh) begin
          modeNext = QVD_ACTIVE;
        end
      end
      QVD_RESTART: begin
        // hold while the reset pin stays low, leave with a restart pulse; a standby drop leaves without one
        if (!pdnHigh) begin
          modeNext = QVD_STANDBY;
        end else if (pinSyncReg[QVD_PIN_RESET]) begin
          modeNext = QVD_ACTIVE;
        end
      end
      default: modeNext = QVD_ACTIVE;
    endcase
    if (rst) begin
      modeNext = QVD_ACTIVE;
    end
  end

  always_ff @(posedge clk) begin
    modeReg  <= modeNext;
    strapReg <= strapNext;
  end

  // ----------------------------------------------------------------
  // configuration registers and gain memory
  // ----------------------------------------------------------------
  logic [31:0]                             ctrlReg;
  logic [31:0]                             ctrlNext;
  qvd_gain_type                            gainCurReg;
  qvd_gain_type                            gainCurNext;
  logic [QVD_CHANNELS-1:0][1:0][QVD_GAIN_W-1:0] gainSavedReg;
  logic [QVD_CHANNELS-1:0][1:0][QVD_GAIN_W-1:0] gainSavedNext;
  logic [31:0]                             rdDataNext;
  logic [3:0]                              phaseReg;

  // standby is not a reset term, so registers ride through it untouched
  always_comb begin
    ctrlNext      = ctrlReg;
    gainCurNext   = gainCurReg;
    gainSavedNext = gainSavedReg;
    if (regWr && regAddr == QVD_CTRL_OFS) begin
      ctrlNext = regWrData & QVD_CTRL_MASK;
      for (int ch = 0; ch < QVD_CHANNELS; ch++) begin
        // composite switch: park the old input's gain, fetch the new one's
        if (!regWrData[QVD_CTRL_SVID+ch] && !ctrlReg[QVD_CTRL_SVID+ch] &&
            regWrData[QVD_CTRL_SEL+ch] != ctrlReg[QVD_CTRL_SEL+ch]) begin
          gainSavedNext[ch][ctrlReg[QVD_CTRL_SEL+ch]] = gainCurReg[ch];
          gainCurNext[ch] = gainSavedReg[ch][regWrData[QVD_CTRL_SEL+ch]];
        end
      end
    end
    for (int ch = 0; ch < QVD_CHANNELS; ch++) begin
      if (regWr && regAddr == qvdGainOfs(ch)) begin
        gainCurNext[ch] = regWrData[QVD_GAIN_W-1:0];
      end
    end
    if (regReset) begin
      ctrlNext      = QVD_CTRL_RESET;
      gainCurNext   = {QVD_CHANNELS{QVD_GAIN_RESET}};
      gainSavedNext = {(2*QVD_CHANNELS){QVD_GAIN_RESET}};
    end
  end

  // read answer in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdDataNext = 32'h0000_0000;
    if (regRd) begin
      if (regAddr == QVD_CTRL_OFS) begin
        rdDataNext = ctrlReg;
      end else if (regAddr == QVD_STATUS_OFS) begin
        rdDataNext[6:0]                = {QVD_SLAVE_BASE, strapReg};
        rdDataNext[QVD_STAT_STBY]      = modeReg == QVD_STANDBY;
        rdDataNext[QVD_STAT_PHASE+:4]  = phaseReg;
      end
      for (int ch = 0; ch < QVD_CHANNELS; ch++) begin
        if (regAddr == qvdGainOfs(ch)) begin
          rdDataNext[QVD_GAIN_W-1:0] = gainCurReg[ch];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    ctrlReg      <= ctrlNext;
    gainCurReg   <= gainCurNext;
    gainSavedReg <= gainSavedNext;
    regRdData    <= rst ? 32'h0000_0000 : rdDataNext;
  end

  // ----------------------------------------------------------------
  // sample buffer
  // ----------------------------------------------------------------
  qvd_sample_type fifoOut;
  logic           fifoOutValid;
  logic           popWord;
  logic           running;

  qvd_fifo #(
    .WIDTH ($bits(qvd_sample_type)),
    .DEPTH (QVD_FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (regReset),
    .inValid  (sampleValid),
    .inReady  (sampleReady),
    .inData   (sampleIn),
    .outValid (fifoOutValid),
    .outReady (popWord),
    .outData  (fifoOut)
  );

  // one word leaves per rising reference edge, so the converter never outruns it
  always_comb begin
    running = modeReg == QVD_ACTIVE;
    popWord = running && refRise;
  end

  // ----------------------------------------------------------------
  // output stage
  // ----------------------------------------------------------------
  logic [1:0]    divReg;
  logic [1:0]    divNext;
  qvd_video_type videoNext;
  logic [3:0]    hsNext;
  logic [3:0]    vsNext;
  logic [3:0]    vsReg;
  logic [3:0]    phaseNext;
  logic [3:0]    fieldNext;
  logic [3:0]    unscaledNext;
  logic [3:0]    scaledNext;

  // clocks stop low in standby; 54 mode runs twice the scaled rate
  always_comb begin
    divNext      = running ? divReg + 2'd1 : 2'd0;
    unscaledNext = {4{running && (ctrlReg[QVD_CTRL_CLK54] ? divReg[0] : divReg[1])}};
    scaledNext   = {4{running && divReg[1]}};
  end

  always_comb begin
    videoNext = running ? channelVideoBus : '0;
    hsNext    = 4'h0;
    vsNext    = running ? vsReg : 4'h0;
    phaseNext = phaseReg;
    if (popWord && fifoOutValid) begin
      vsNext[fifoOut.chan] = fifoOut.fieldStart;
      if (ctrlReg[QVD_CTRL_EMBED] && fifoOut.lineStart) begin
        videoNext[fifoOut.chan] = QVD_SYNC_CODE;
      end else begin
        videoNext[fifoOut.chan] = fifoOut.value[QVD_SAMPLE_W-1 -: QVD_VIDEO_W];
        hsNext[fifoOut.chan]    = fifoOut.lineStart && !ctrlReg[QVD_CTRL_EMBED];
      end
      // lines alternate phase, each field opens on a noninverted line
      if (fifoOut.fieldStart) begin
        phaseNext[fifoOut.chan] = 1'b1;
      end else if (fifoOut.lineStart) begin
        phaseNext[fifoOut.chan] = !phaseReg[fifoOut.chan];
      end
    end
    if (regReset) begin
      phaseNext = 4'hf;
    end
    fieldNext = ctrlReg[QVD_CTRL_LINE_PHASE_INDICATOR] ? phaseNext : vsNext;
  end

  always_ff @(posedge clk) begin
    divReg             <= rst ? 2'd0 : divNext;
    channelVideoBus    <= rst ? '0 : videoNext;
    lineSyncOut        <= rst ? 4'h0 : hsNext;
    vsReg              <= rst ? 4'h0 : vsNext;
    phaseReg           <= phaseNext;
    fieldSyncOut       <= rst ? 4'h0 : fieldNext;
    unscaledPixelClock <= rst ? 4'h0 : unscaledNext;
    scaledPixelClock   <= rst ? 4'h0 : scaledNext;
    sampleStrobe       <= rst ? 1'b0 : popWord && fifoOutValid;  // empty pops give no strobe
  end

  // configuration seen by the analog side
  always_comb begin
    inputSelect   = ctrlReg[QVD_CTRL_SEL+:4] & ~ctrlReg[QVD_CTRL_SVID+:4];
    sVideoMode    = ctrlReg[QVD_CTRL_SVID+:4];
    agcGain       = gainCurReg;
    standbyActive = modeReg == QVD_STANDBY;
    cpuRestart    = modeReg == QVD_RESTART && pinSyncReg[QVD_PIN_RESET];
    slaveAddress  = {QVD_SLAVE_BASE, strapReg};
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence pdnDrop;
    pdnHigh ##1 !pdnHigh;
  endsequence

  AST_LINE_PHASE_INDICATOR_PHASE: assert property (@(posedge clk) disable iff (rst)
    ctrlNext[QVD_CTRL_LINE_PHASE_INDICATOR] && ctrlReg[QVD_CTRL_LINE_PHASE_INDICATOR] |=> fieldSyncOut == phaseReg)
    else $error("indicator does not follow line phase");
  AST_STANDBY_ENTRY: assert property (@(posedge clk) disable iff (rst)
    pdnDrop |=> standbyActive)
    else $error("standby not entered");
  AST_STANDBY_KEEPS: assert property (@(posedge clk) disable iff (rst)
    standbyActive && !regWr |=> $stable(ctrlReg) && $stable(gainCurReg))
    else $error("registers changed in standby");
  AST_RESET_DEFAULT: assert property (@(posedge clk) disable iff (rst)
    pdnHigh && !pinSyncReg[QVD_PIN_RESET] |=> ctrlReg == QVD_CTRL_RESET && agcGain[0] == QVD_GAIN_RESET)
    else $error("chip reset left registers dirty");
  AST_STRAP_HOLD: assert property (@(posedge clk) disable iff (rst)
    $stable(slaveAddress))
    else $error("slave address moved after reset");
  AST_STRAP_TAKE: assert property (@(posedge clk)
    rst ##1 !rst |-> slaveAddress[1:0] == $past(pinSyncReg[QVD_PIN_STRAP1:QVD_PIN_STRAP0]))
    else $error("strap pins not sampled together");
  AST_SCALED_RATE: assert property (@(posedge clk) disable iff (rst)
    running && $past(running, 3) && !$past(rst, 3)
    |-> scaledPixelClock[0] != $past(scaledPixelClock[0], 2))
    else $error("scaled clock not at half rate");
  AST_UNSCALED_54: assert property (@(posedge clk) disable iff (rst)
    running && $past(running, 2) && ctrlReg[QVD_CTRL_CLK54] && $past(ctrlReg[QVD_CTRL_CLK54])
    && $past(ctrlReg[QVD_CTRL_CLK54], 2)
    |-> unscaledPixelClock[0] != $past(unscaledPixelClock[0]))
    else $error("54 mode clock not toggling every cycle");
  AST_STROBE_GAP: assert property (@(posedge clk) disable iff (rst)
    sampleStrobe |=> !sampleStrobe)
    else $error("samples faster than reference");
  AST_GAIN_RESTORE: assert property (@(posedge clk) disable iff (regReset)
    regWr && regAddr == QVD_CTRL_OFS && !regWrData[QVD_CTRL_SVID] && !ctrlReg[QVD_CTRL_SVID]
    && regWrData[QVD_CTRL_SEL] != ctrlReg[QVD_CTRL_SEL]
    |=> agcGain[0] == $past(gainSavedReg[0][regWrData[QVD_CTRL_SEL]]))
    else $error("gain not restored on input switch");
  AST_HS_DISCRETE: assert property (@(posedge clk) disable iff (rst)
    |lineSyncOut |-> $past(!ctrlReg[QVD_CTRL_EMBED]))
    else $error("discrete sync in embedded mode");

endmodule : qvd_ctrl_port
`default_nettype wire

// ==== testbench/qvd_video_rx.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------------
// receiver model: takes each word as the strobe marks it
// ------------------------------------------------------------------
module qvd_video_rx
  import qvd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          sampleStrobe,
  input  wire qvd_video_type channelVideoBus,
  input  wire logic [3:0]    lineSyncOut,
  input  wire logic [3:0]    fieldSyncOut,
  input  wire logic [3:0]    unscaledPixelClock,
  input  wire logic [3:0]    scaledPixelClock,
  output qvd_video_type      gotBus_reg,
  output logic [3:0]         gotLine_reg,
  output logic [3:0]         gotField_reg,
  output int                 nStrobe_reg,
  output int                 nUnscaled_reg,
  output int                 nScaled_reg
);
  logic unscaledLast_reg;
  logic scaledLast_reg;

  // capture words and count clock rises; the clocks are only sampled, so
  // a wrong divide ratio shows as a wrong count over a fixed window
  always_ff @(posedge clk) begin
    if (rst) begin
      gotBus_reg       <= '0;
      gotLine_reg      <= 4'h0;
      gotField_reg     <= 4'h0;
      nStrobe_reg      <= 0;
      nUnscaled_reg    <= 0;
      nScaled_reg      <= 0;
      unscaledLast_reg <= 1'b0;
      scaledLast_reg   <= 1'b0;
    end else begin
      if (sampleStrobe) begin
        gotBus_reg   <= channelVideoBus;
        gotLine_reg  <= lineSyncOut;
        gotField_reg <= fieldSyncOut;
        nStrobe_reg  <= nStrobe_reg + 1;
      end
      if (unscaledPixelClock[0] && !unscaledLast_reg) begin
        nUnscaled_reg <= nUnscaled_reg + 1;
      end
      if (scaledPixelClock[0] && !scaledLast_reg) begin
        nScaled_reg <= nScaled_reg + 1;      // qualifier clock
      end
      unscaledLast_reg <= unscaledPixelClock[0];
      scaledLast_reg   <= scaledPixelClock[0];
    end
  end
endmodule : qvd_video_rx
`default_nettype wire

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import qvd_pkg::*;
  logic           clk, rst, standbyRequestN, chipResetLow, addrStrapBit0, addrStrapBit1;
  logic           testModeSelect, refClockIn, refRun, sampleValid, regWr, regRd;
  logic           sampleReady, sampleStrobe, standbyActive, cpuRestart;
  qvd_sample_type sampleIn;
  logic [7:0]     regAddr;
  logic [31:0]    regWrData, regRdData, rd;
  logic [3:0]     unscaledPixelClock, scaledPixelClock, lineSyncOut, fieldSyncOut;
  logic [3:0]     inputSelect, sVideoMode, gotLine, gotField;
  qvd_video_type  channelVideoBus, gotBus;
  qvd_gain_type   agcGain;
  logic [6:0]     slaveAddress;
  int             n_mismatch, checks, nStrobe, nUnscaled, nScaled, base, base2;

  qvd_ctrl_port uut (.clk(clk), .rst(rst), .standbyRequestN(standbyRequestN),
    .chipResetLow(chipResetLow), .addrStrapBit0(addrStrapBit0),
    .addrStrapBit1(addrStrapBit1), .testModeSelect(testModeSelect),
    .refClockIn(refClockIn), .sampleIn(sampleIn), .sampleValid(sampleValid),
    .sampleReady(sampleReady), .sampleStrobe(sampleStrobe), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .unscaledPixelClock(unscaledPixelClock), .scaledPixelClock(scaledPixelClock),
    .lineSyncOut(lineSyncOut), .fieldSyncOut(fieldSyncOut),
    .channelVideoBus(channelVideoBus), .inputSelect(inputSelect),
    .sVideoMode(sVideoMode), .agcGain(agcGain), .standbyActive(standbyActive),
    .cpuRestart(cpuRestart), .slaveAddress(slaveAddress));

  qvd_video_rx rx (.clk(clk), .rst(rst), .sampleStrobe(sampleStrobe),
    .channelVideoBus(channelVideoBus), .lineSyncOut(lineSyncOut),
    .fieldSyncOut(fieldSyncOut), .unscaledPixelClock(unscaledPixelClock),
    .scaledPixelClock(scaledPixelClock), .gotBus_reg(gotBus), .gotLine_reg(gotLine),
    .gotField_reg(gotField), .nStrobe_reg(nStrobe), .nUnscaled_reg(nUnscaled),
    .nScaled_reg(nScaled));

  // ------------------------------------------------------------------
  // clocks and watchdog
  // ------------------------------------------------------------------
  // system clock, 25 ns
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // reference pin, 200 ns, phase unrelated; pausable so the buffer can fill
  initial begin
    refClockIn = 1'b0;
    #37;
    forever begin
      #100;
      if (refRun) refClockIn = ~refClockIn;
    end
  end
  // whole run is a few hundred cycles; 2 ms is far beyond it
  initial begin
    #2000000;
    n_mismatch++;
    end_of_test();
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
    #1;
  endtask : regWrite

  // read data stand only in the cycle after the strobe
  task automatic regRead(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : regRead

  // hold the word until the edge that sees ready high
  task automatic pushWord(input logic [1:0] ch, input logic [8:0] v, input logic ls,
                          input logic fs);
    @(posedge clk);
    sampleIn    <= '{chan: ch, value: v, lineStart: ls, fieldStart: fs};
    sampleValid <= 1'b1;
    #1;
    while (sampleReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    sampleValid <= 1'b0;
  endtask : pushWord

  task automatic waitWord(input int want);
    for (int k = 0; k < 400 && nStrobe < want; k++) cyc(1);
    chk("strobe count", want, nStrobe);
  endtask : waitWord

  task automatic note(input string s);
    $display("test %s done, mismatches %0d", s, n_mismatch);
  endtask : note

  // ------------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    standbyRequestN = 1'b1;
    chipResetLow = 1'b1;
    addrStrapBit0 = 1'b0;
    addrStrapBit1 = 1'b1;
    testModeSelect = 1'b0;  // held at ground
    refRun = 1'b1;
    sampleValid = 1'b0;
    sampleIn = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWrData = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // straps taken in reset, later changes ignored
    addrStrapBit0 <= 1'b1;
    addrStrapBit1 <= 1'b0;
    cyc(6);
    chk("slave port", {25'h0, QVD_SLAVE_BASE, 2'b10}, 32'(slaveAddress));
    regRead(QVD_STATUS_OFS, rd);
    chk("slave status", {25'h0, QVD_SLAVE_BASE, 2'b10}, {25'h0, rd[6:0]});
    note("strap");
    // register map: mask, unmapped read and write
    regWrite(QVD_CTRL_OFS, 32'hffff_ffff);
    regRead(QVD_CTRL_OFS, rd);
    chk("ctrl mask", QVD_CTRL_MASK, rd);
    regWrite(8'h3c, 32'h0000_0000);
    regRead(8'h3c, rd);
    chk("unmapped", 32'h0000_0000, rd);
    regRead(QVD_CTRL_OFS, rd);
    chk("ctrl kept", QVD_CTRL_MASK, rd);
    note("regs");
    // pixel clocks over a 64-cycle window
    regWrite(QVD_CTRL_OFS, 32'h0000_0001);
    base = nUnscaled;
    base2 = nScaled;
    cyc(64);
    chk("fast clock", 32, nUnscaled - base);
    chk("scaled clock", 16, nScaled - base2);
    regWrite(QVD_CTRL_OFS, 32'h0000_0000);
    base = nUnscaled;
    cyc(64);
    chk("slow clock", 16, nUnscaled - base);
    note("clocks");
    // standby keeps configuration, stops outputs
    regWrite(QVD_CTRL_OFS, 32'h0000_0a51);
    standbyRequestN <= 1'b0;
    cyc(6);
    chk("standby", 1, 32'(standbyActive));
    regRead(QVD_STATUS_OFS, rd);
    chk("status standby", 1, 32'(rd[QVD_STAT_STBY]));
    base = nUnscaled;
    cyc(16);
    chk("clock stopped", 0, nUnscaled - base);
    chk("bus idle", 0, 32'(channelVideoBus));
    standbyRequestN <= 1'b1;
    cyc(6);
    chk("awake", 0, 32'(standbyActive));
    regRead(QVD_CTRL_OFS, rd);
    chk("ctrl after standby", 32'h0000_0a51, rd);
    note("standby");
    // chip reset with standby pin high
    chipResetLow <= 1'b0;
    cyc(8);
    chipResetLow <= 1'b1;
    for (int k = 0; k < 20 && cpuRestart !== 1'b1; k++) cyc(1);
    chk("restart", 1, 32'(cpuRestart));
    cyc(2);
    regRead(QVD_CTRL_OFS, rd);
    chk("ctrl default", QVD_CTRL_RESET, rd);
    regRead(QVD_GAIN_BASE, rd);
    chk("gain default", 32'(QVD_GAIN_RESET), rd);
    note("chip reset");
    // gain memory across composite switches
    regWrite(QVD_GAIN_BASE, 32'h0000_0033);
    regWrite(QVD_CTRL_OFS, 32'h0000_0010);
    chk("gain b", 32'(QVD_GAIN_RESET), 32'(agcGain[0]));
    regWrite(QVD_GAIN_BASE, 32'h0000_0055);
    regWrite(QVD_CTRL_OFS, 32'h0000_0000);
    chk("gain a back", 32'h33, 32'(agcGain[0]));
    regWrite(QVD_CTRL_OFS, 32'h0000_0010);
    chk("gain b back", 32'h55, 32'(agcGain[0]));
    regWrite(QVD_CTRL_OFS, 32'h0000_0180);
    chk("select", 32'h8, 32'(inputSelect));
    regWrite(QVD_CTRL_OFS, 32'h0000_0110);
    chk("svideo select", 32'h0, 32'(inputSelect));
    chk("svideo mode", 32'h1, 32'(sVideoMode));
    regWrite(QVD_CTRL_OFS, 32'h0000_0000);
    note("inputs");
    // buffer fills with the reference paused, then drains
    refRun = 1'b0;
    cyc(20);
    base = nStrobe;
    for (int i = 0; i < QVD_FIFO_DEPTH; i++) pushWord(2'd0, 9'(2 * i + 2), 1'b0, 1'b0);
    cyc(2);
    chk("full refuses", 0, 32'(sampleReady));
    refRun = 1'b1;
    waitWord(base + QVD_FIFO_DEPTH);
    chk("last word", 32'h10, 32'(gotBus[0]));
    chk("drained", 1, 32'(sampleReady));
    note("buffer");
    // discrete syncs, line phase, embedded code
    pushWord(2'd2, 9'h1a5, 1'b1, 1'b0);
    waitWord(nStrobe + 1);
    chk("bus ch2", 32'hd2, 32'(gotBus[2]));
    chk("line sync", 32'h4, 32'(gotLine));
    regWrite(QVD_CTRL_OFS, 32'h0000_0004);
    pushWord(2'd1, 9'h0aa, 1'b0, 1'b1);
    waitWord(nStrobe + 1);
    chk("phase field", 1, 32'(gotField[1]));
    pushWord(2'd1, 9'h0ab, 1'b1, 1'b0);
    waitWord(nStrobe + 1);
    chk("phase line", 0, 32'(gotField[1]));
    chk("bus ch1", 32'h55, 32'(gotBus[1]));
    regWrite(QVD_CTRL_OFS, 32'h0000_0006);
    pushWord(2'd3, 9'h044, 1'b1, 1'b0);
    waitWord(nStrobe + 1);
    chk("embedded code", 32'(QVD_SYNC_CODE), 32'(gotBus[3]));
    chk("no line pulse", 0, 32'(gotLine));
    note("stream");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
